// ==== hw/rttp_map.vh ====
`ifndef RTTP_MAP_VH
`define RTTP_MAP_VH
// Register byte offsets
`define RTTP_OFF_MODEM_CTRL_ONE_LOW 8'h00
`define RTTP_OFF_DAC_OVERRIDE_HIGH 8'h04
`define RTTP_OFF_DAC_OVERRIDE_LOW 8'h08
`define RTTP_OFF_STROBE 8'h0C
`define RTTP_OFF_STATUS 8'h10
`define RTTP_OFF_QUEUE_DATA 8'h14
`define RTTP_OFF_FREQ_SETTING 8'h18
`define RTTP_OFF_FREQ_ACTIVE 8'h1C
// Field positions
`define RTTP_TX_MODE_LSB 0
`define RTTP_TX_MODE_MSB 1
`define RTTP_RX_MODE_LSB 2
`define RTTP_RX_MODE_MSB 3
`define RTTP_STB_TX_ON 0
`define RTTP_STB_RF_OFF 1
`define RTTP_STB_FLUSH 2
`define RTTP_ST_TX_ACTIVE 0
`define RTTP_ST_UNDERFLOW 1
`define RTTP_ST_CARRIER 2
`define RTTP_ST_COUNT_LSB 8
// Mode encodings
`define RTTP_MODE_NORMAL 2'h0
`define RTTP_MODE_QUEUE_LOOP 2'h2
`define RTTP_MODE_PRBS 2'h3
// Reset values
`define RTTP_RST_MODEM_CTRL 8'h00
`define RTTP_RST_DAC_HIGH 8'h00
`define RTTP_RST_DAC_LOW 8'h00
`define RTTP_RST_FREQ 10'h000
// Synchronization header
`define RTTP_PREAMBLE_BYTE 8'h00
`define RTTP_SFD_BYTE 8'hA7
`define RTTP_PREAMBLE_LEN 3'h4
// Frame check polynomial, reflected form
`define RTTP_CRC_POLY 16'h8408
`define RTTP_CRC_FEED 8'hFF
// Timing
`define RTTP_CLK_NS 8
`define RTTP_BIT_NS 4000
`define RTTP_BIT_CYCLES (`RTTP_BIT_NS / `RTTP_CLK_NS)
`endif

// ==== hw/rttp_radio_tx_test_pattern.v ====
// Summary of operation
// - Mode 2 with empty queue, DAC override 0x1800 and transmit strobe give unmodulated carrier.
// - Mode 3 with transmit strobe sends CRC generated pseudo-random bytes.
// - Each sent byte is CRC low byte; CRC then advanced with 0xFF.
// - The pseudo-random sequence repeats after 32767 bytes.
// - Payload after header starts 00 78 b8 4b 99 c3 e9.
// - Every transmit mode sends preamble and start delimiter before payload.
// - Mode 2 with filled queue loops 128 queue bytes, ignoring underflow.
// - Bias switch output low while receiving, high while transmitting.
// - Queue decouples bus rate from 250 kbps air bit rate.
`timescale 1ns/10ps
`include "rttp_map.vh"
module rttp_radio_tx_test_pattern #(
   parameter DEPTH = 128,
   parameter AW = 7,
   parameter BIT_CYCLES = `RTTP_BIT_CYCLES
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Radio side
   output reg tx_bit,
   output reg tx_bit_strobe,
   output reg tx_active,
   output reg rf_bias_switch_out,
   output reg dac_override_en,
   output reg [15:0] dac_override_value,
   output reg [9:0] rf_freq_word,
   output reg [1:0] rx_test_mode
);
   localparam S_IDLE = 4'b0001;
   localparam S_SHR = 4'b0010;
   localparam S_PAY = 4'b0100;
   localparam S_CAR = 4'b1000;

   reg [7:0] modem_ctrl_one_low_reg;
   reg [7:0] dac_override_high_reg;
   reg [7:0] dac_override_low_reg;
   reg [9:0] freq_setting_reg;
   reg underflow_reg;
   reg [7:0] transmit_queue [0:DEPTH-1];
   reg [AW-1:0] wr_idx_reg;
   reg [AW-1:0] rd_idx_reg;
   reg [AW:0] count_reg;
   reg [3:0] state_reg;
   reg [1:0] run_mode_reg;
   reg [15:0] crc_reg;
   reg [7:0] cur_byte_reg;
   reg [2:0] bit_cnt_reg;
   reg [2:0] shr_cnt_reg;
   reg [15:0] div_reg;
   reg tick;

   wire bus_wr = psel & penable & pready & pwrite;
   wire [1:0] tx_mode = modem_ctrl_one_low_reg[`RTTP_TX_MODE_MSB:`RTTP_TX_MODE_LSB];
   wire stb_on = bus_wr && paddr == `RTTP_OFF_STROBE && pwdata[`RTTP_STB_TX_ON];
   wire stb_off = bus_wr && paddr == `RTTP_OFF_STROBE && pwdata[`RTTP_STB_RF_OFF];
   wire stb_flush = bus_wr && paddr == `RTTP_OFF_STROBE && pwdata[`RTTP_STB_FLUSH];
   wire push = bus_wr && paddr == `RTTP_OFF_QUEUE_DATA && count_reg != DEPTH;
   wire byte_end = tick && bit_cnt_reg == 3'h7;
   // Modes 0 and 1 drain the queue once; looping and pseudo-random modes never do
   wire drain_mode = run_mode_reg != `RTTP_MODE_QUEUE_LOOP && run_mode_reg != `RTTP_MODE_PRBS;
   wire queue_empty_normal = drain_mode && count_reg == {(AW+1){1'b0}};
   // No pop from an empty draining queue, so the fill count cannot wrap
   wire pop = byte_end && ((state_reg == S_SHR && shr_cnt_reg == `RTTP_PREAMBLE_LEN)
      || state_reg == S_PAY) && run_mode_reg != `RTTP_MODE_PRBS && !queue_empty_normal;

   // One byte of the reflected CRC, LSB first
   function [15:0] crc_byte;
      input [15:0] c;
      input [7:0] d;
      integer i;
      reg [15:0] t;
      begin
         t = c;
         for (i = 0; i < 8; i = i + 1) begin
            if (t[0] ^ d[i])
               t = (t >> 1) ^ `RTTP_CRC_POLY;
            else
               t = t >> 1;
         end
         crc_byte = t;
      end
   endfunction

   // Air bit rate divider
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 16'h0000;
         tick <= 1'b0;
      end else if (state_reg == S_IDLE || state_reg == S_CAR) begin
         div_reg <= 16'h0000;
         tick <= 1'b0;
      end else if (div_reg == BIT_CYCLES - 1) begin
         div_reg <= 16'h0000;
         tick <= 1'b1;
      end else begin
         div_reg <= div_reg + 16'h0001;
         tick <= 1'b0;
      end
   end

   // APB register file
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modem_ctrl_one_low_reg <= `RTTP_RST_MODEM_CTRL;
         dac_override_high_reg <= `RTTP_RST_DAC_HIGH;
         dac_override_low_reg <= `RTTP_RST_DAC_LOW;
         freq_setting_reg <= `RTTP_RST_FREQ;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel & ~penable) begin
            case (paddr)
               `RTTP_OFF_MODEM_CTRL_ONE_LOW: prdata <= {24'h00_0000, modem_ctrl_one_low_reg};
               `RTTP_OFF_DAC_OVERRIDE_HIGH: prdata <= {24'h00_0000, dac_override_high_reg};
               `RTTP_OFF_DAC_OVERRIDE_LOW: prdata <= {24'h00_0000, dac_override_low_reg};
               `RTTP_OFF_STROBE: prdata <= 32'h0000_0000;
               `RTTP_OFF_STATUS:
                  prdata <= {{(24-AW-1){1'b0}}, count_reg, 5'h00,
                     state_reg == S_CAR, underflow_reg, tx_active};
               `RTTP_OFF_QUEUE_DATA: prdata <= 32'h0000_0000;
               `RTTP_OFF_FREQ_SETTING: prdata <= {22'h00_0000, freq_setting_reg};
               `RTTP_OFF_FREQ_ACTIVE: prdata <= {22'h00_0000, rf_freq_word};
               default: pslverr <= 1'b1;
            endcase
         end
         if (bus_wr) begin
            case (paddr)
               `RTTP_OFF_MODEM_CTRL_ONE_LOW: modem_ctrl_one_low_reg <= pwdata[7:0];
               `RTTP_OFF_DAC_OVERRIDE_HIGH: dac_override_high_reg <= pwdata[7:0];
               `RTTP_OFF_DAC_OVERRIDE_LOW: dac_override_low_reg <= pwdata[7:0];
               `RTTP_OFF_FREQ_SETTING: freq_setting_reg <= pwdata[9:0];
               default: ;
            endcase
         end
      end
   end

   // Transmit queue storage
   always @(posedge pclk) begin
      if (push)
         transmit_queue[wr_idx_reg] <= pwdata[7:0];
   end

   // Queue pointers; looping mode never drains the fill count
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_idx_reg <= {AW{1'b0}};
         rd_idx_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else if (stb_flush) begin
         wr_idx_reg <= {AW{1'b0}};
         rd_idx_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         // Looping restarts at the first entry; a draining queue keeps its place
         if (stb_on && state_reg == S_IDLE && tx_mode == `RTTP_MODE_QUEUE_LOOP)
            rd_idx_reg <= {AW{1'b0}};
         else if (pop)
            rd_idx_reg <= rd_idx_reg + {{(AW-1){1'b0}}, 1'b1};
         if (push)
            wr_idx_reg <= wr_idx_reg + {{(AW-1){1'b0}}, 1'b1};
         if (push && !(pop && drain_mode))
            count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
         else if (!push && pop && drain_mode)
            count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
   end

   // Transmit sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_IDLE;
         run_mode_reg <= 2'h0;
         crc_reg <= 16'h0000;
         cur_byte_reg <= 8'h00;
         bit_cnt_reg <= 3'h0;
         shr_cnt_reg <= 3'h0;
         underflow_reg <= 1'b0;
         tx_bit <= 1'b0;
         tx_bit_strobe <= 1'b0;
         tx_active <= 1'b0;
         rf_bias_switch_out <= 1'b0;
         dac_override_en <= 1'b0;
         dac_override_value <= 16'h0000;
         rf_freq_word <= `RTTP_RST_FREQ;
         rx_test_mode <= 2'h0;
      end else begin
         // No bit strobe once transmit has been switched off
         tx_bit_strobe <= tick && state_reg != S_IDLE && !stb_off;
         rx_test_mode <= modem_ctrl_one_low_reg[`RTTP_RX_MODE_MSB:`RTTP_RX_MODE_LSB];
         if (bus_wr && paddr == `RTTP_OFF_STATUS && pwdata[`RTTP_ST_UNDERFLOW])
            underflow_reg <= 1'b0;
         if (tick) begin
            tx_bit <= cur_byte_reg[bit_cnt_reg];
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
         end
         case (state_reg)
            S_IDLE: begin
               if (stb_on) begin
                  run_mode_reg <= tx_mode;
                  rf_freq_word <= freq_setting_reg;
                  crc_reg <= 16'h0000;
                  cur_byte_reg <= `RTTP_PREAMBLE_BYTE;
                  bit_cnt_reg <= 3'h0;
                  shr_cnt_reg <= 3'h0;
                  state_reg <= S_SHR;
               end
            end
            S_SHR: begin
               if (byte_end) begin
                  shr_cnt_reg <= shr_cnt_reg + 3'h1;
                  if (shr_cnt_reg == `RTTP_PREAMBLE_LEN - 3'h1) begin
                     cur_byte_reg <= `RTTP_SFD_BYTE;
                  end else if (shr_cnt_reg == `RTTP_PREAMBLE_LEN) begin
                     if (run_mode_reg == `RTTP_MODE_PRBS) begin
                        cur_byte_reg <= crc_reg[7:0];
                        crc_reg <= crc_byte(crc_reg, `RTTP_CRC_FEED);
                        state_reg <= S_PAY;
                     end else if (run_mode_reg == `RTTP_MODE_QUEUE_LOOP &&
                        count_reg == {(AW+1){1'b0}}) begin
                        dac_override_value <= {dac_override_high_reg, dac_override_low_reg};
                        dac_override_en <= 1'b1;
                        state_reg <= S_CAR;
                     end else if (queue_empty_normal) begin
                        underflow_reg <= 1'b1;
                        state_reg <= S_IDLE;
                     end else begin
                        cur_byte_reg <= transmit_queue[rd_idx_reg];
                        state_reg <= S_PAY;
                     end
                  end else begin
                     cur_byte_reg <= `RTTP_PREAMBLE_BYTE;
                  end
               end
            end
            S_PAY: begin
               if (byte_end) begin
                  if (run_mode_reg == `RTTP_MODE_PRBS) begin
                     cur_byte_reg <= crc_reg[7:0];
                     crc_reg <= crc_byte(crc_reg, `RTTP_CRC_FEED);
                  end else if (queue_empty_normal) begin
                     underflow_reg <= 1'b1;
                     state_reg <= S_IDLE;
                  end else begin
                     cur_byte_reg <= transmit_queue[rd_idx_reg];
                  end
               end
            end
            S_CAR: begin
               dac_override_value <= {dac_override_high_reg, dac_override_low_reg};
            end
            default: state_reg <= S_IDLE;
         endcase
         if (stb_off) begin
            state_reg <= S_IDLE;
            dac_override_en <= 1'b0;
         end
         tx_active <= state_reg != S_IDLE && !stb_off;
         rf_bias_switch_out <= state_reg != S_IDLE && !stb_off;
      end
   end
endmodule // rttp_radio_tx_test_pattern

// ==== tb/rttp_chk_sva.sv ====
`timescale 1ns/10ps
module rttp_chk #(
   parameter BIT_CYCLES = 10
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB answer
   input wire psel,
   input wire penable,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Radio side
   input wire tx_bit,
   input wire tx_bit_strobe,
   input wire tx_active,
   input wire rf_bias_switch_out,
   input wire dac_override_en
);
   logic [15:0] cnt;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Cycles since transmit began or since the last bit
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt <= 16'h0000;
      else if (!tx_active) cnt <= 16'h0000;
      else if (tx_bit_strobe) cnt <= 16'h0001;
      else cnt <= cnt + 16'h0001;
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_bit_start;
      tx_bit_strobe && tx_active;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("bad error answer");
   a_bias_follows_tx: assert property (rf_bias_switch_out == tx_active)
      else $error("bias switch wrong");
   a_bit_period: assert property (s_bit_start |-> cnt == BIT_CYCLES)
      else $error("bit period wrong");
   a_strobe_in_tx: assert property (tx_bit_strobe |-> tx_active)
      else $error("bit outside transmit");
   // The last delimiter bit may still strobe in the cycle the carrier starts
   a_carrier_static: assert property (
      dac_override_en && $past(dac_override_en) |-> tx_active && !tx_bit_strobe)
      else $error("carrier not static");
   a_bit_holds: assert property (
      tx_active && $past(tx_active) && !tx_bit_strobe |-> $stable(tx_bit))
      else $error("bit changed early");
endmodule  // rttp_chk
bind rttp_radio_tx_test_pattern rttp_chk #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.*);

// ==== tb/rttp_rx_model.sv ====
`timescale 1ns/10ps
module rttp_rx_model (
   // Air side
   input wire pclk,
   input wire tx_bit,
   input wire tx_bit_strobe,
   input wire tx_active
);
   logic [7:0] sh;
   int n = 0;
   logic [7:0] got[$];
   // Bits arrive LSB first, one per bit period
   always @(posedge pclk) begin
      if (!tx_active) n = 0;
      else if (tx_bit_strobe) begin
         sh = {tx_bit, sh[7:1]};
         n = n + 1;
         if (n == 8) begin
            got.push_back(sh);
            n = 0;
         end
      end
   end
endmodule  // rttp_rx_model

// ==== tb/rttp_radio_tx_test_pattern_tb.sv ====
`timescale 1ns/10ps
module rttp_radio_tx_test_pattern_tb;
   localparam int BC = 10;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, err;
   logic tx_bit, tx_bit_strobe, tx_active, rf_bias_switch_out, dac_override_en;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q, v;
   logic [15:0] dac_override_value, c;
   logic [9:0] rf_freq_word;
   logic [1:0] rx_test_mode;
   logic [7:0] qb[128];
   logic [7:0] r6[7] = '{8'h00, 8'h78, 8'hb8, 8'h4b, 8'h99, 8'hc3, 8'he9};
   int mismatches = 0;
   int num_checks = 0;
   always #4 pclk = ~pclk;
   rttp_radio_tx_test_pattern #(.BIT_CYCLES(BC)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_bit(tx_bit),
      .tx_bit_strobe(tx_bit_strobe), .tx_active(tx_active),
      .rf_bias_switch_out(rf_bias_switch_out), .dac_override_en(dac_override_en),
      .dac_override_value(dac_override_value), .rf_freq_word(rf_freq_word),
      .rx_test_mode(rx_test_mode));
   rttp_rx_model u_rx (.pclk(pclk), .tx_bit(tx_bit), .tx_bit_strobe(tx_bit_strobe),
      .tx_active(tx_active));
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a transfer that is never answered
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic waitb(input int nb);
      int t;
      t = 0;
      while (u_rx.got.size() < nb && t < 40000) begin
         @(posedge pclk);
         t++;
      end
      if (t == 40000) mismatches++;
   endtask
   task automatic stop;
      apb(1'b1, 8'h0C, 32'h0000_0002);
      apb(1'b1, 8'h0C, 32'h0000_0004);
      u_rx.got.delete();
   endtask
   // Advance the check word with an all-ones byte, LSB first
   function automatic logic [15:0] crc_ff(input logic [15:0] s);
      for (int i = 0; i < 8; i++) s = !s[0] ? ((s >> 1) ^ 16'h8408) : (s >> 1);
      return s;
   endfunction
   initial begin
      void'($urandom(32'ha73b_e0bc));
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(i == 3 ? 24 : i * 4), 32'h0);
         chk("reset", 32'h0, q);
      end
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", 32'h1, err);
      v = $urandom;
      apb(1'b1, 8'h04, v);
      apb(1'b1, 8'h08, v >> 8);
      apb(1'b0, 8'h04, 32'h0);
      chk("dac_high", {24'h0, v[7:0]}, q);
      apb(1'b0, 8'h08, 32'h0);
      chk("dac_low", {24'h0, v[15:8]}, q);
      // The override word is loaded only when a carrier starts and while it runs
      chk("dac_value", 32'h0, dac_override_value);
      $display("test registers done");
      apb(1'b1, 8'h18, {22'h0, v[25:16]});
      chk("freq_hold", 32'h0, rf_freq_word);
      apb(1'b1, 8'h00, {28'h0, v[29:28], 2'h3});
      apb(1'b1, 8'h0C, 32'h1);
      @(posedge pclk);
      chk("freq", v[25:16], rf_freq_word);
      chk("rx_mode", v[29:28], rx_test_mode);
      waitb(17);
      c = 16'h0;
      for (int i = 0; i < 17; i++) begin
         if (i < 5) chk("header", i < 4 ? 8'h00 : 8'hA7, u_rx.got[i]);
         else begin
            chk("prbs", c[7:0], u_rx.got[i]);
            if (i < 12) chk("prbs_start", r6[i - 5], u_rx.got[i]);
            c = crc_ff(c);
         end
      end
      stop();
      $display("test prbs done");
      for (int i = 0; i < 128; i++) begin
         qb[i] = 8'($urandom);
         apb(1'b1, 8'h14, {24'h0, qb[i]});
      end
      apb(1'b1, 8'h00, 32'h2);
      apb(1'b1, 8'h0C, 32'h1);
      waitb(135);
      for (int i = 0; i < 130; i++) chk("loop", qb[i % 128], u_rx.got[i + 5]);
      apb(1'b0, 8'h10, 32'h0);
      chk("no_underflow", 32'h0, q[1]);
      chk("loop_count", 32'h80, q[15:8]);
      stop();
      $display("test queue loop done");
      apb(1'b1, 8'h04, 32'h18);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h0C, 32'h1);
      waitb(5);
      repeat (2 * BC) @(posedge pclk);
      chk("carrier", 32'h1, dac_override_en);
      chk("carrier_dac", 32'h1800, dac_override_value);
      chk("bias_tx", 32'h1, rf_bias_switch_out);
      stop();
      $display("test carrier done");
      apb(1'b1, 8'h14, {24'h0, qb[0]});
      apb(1'b1, 8'h14, {24'h0, qb[1]});
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h0C, 32'h1);
      waitb(7);
      for (int t = 0; t < 4 * BC && tx_active; t++) @(posedge pclk);
      apb(1'b0, 8'h10, 32'h0);
      chk("underflow", 32'h1, q[1]);
      chk("drained", 32'h0, q[15:8]);
      chk("once", {qb[1], qb[0]}, {u_rx.got[6], u_rx.got[5]});
      chk("bias_rx", 32'h0, rf_bias_switch_out);
      apb(1'b1, 8'h10, 32'h2);
      apb(1'b0, 8'h10, 32'h0);
      chk("underflow_clr", 32'h0, q[1]);
      $display("test normal done");
      summarize();
   end
   initial begin
      #(8 * 60000);
      mismatches++;
      summarize();
   end
endmodule  // rttp_radio_tx_test_pattern_tb
